// ===== trig_route_pkg.sv
// Constants shared by the front trigger port router and its line mux.
// Assumes one synchronous clock domain and no software register bus.
//
// Contract
// - One active driver per line and segment.
// - Input port fans out to many lines.
// - Output port sourced from one line.
// - Ports always active, changes apply immediately.
// - Input default selects no lines at all.
// - Conflicting settings accepted, never rejected.
// - Input selection dropped where bridge route exists.
package trig_route_pkg;

  localparam int NUM_PORTS = 2;
  localparam int NUM_LINES = 8;
  localparam int NUM_SEGS = 2;
  localparam int SEL_W = 3;

  // Index of segment 2 and segment 3 within the segment dimension.
  localparam int SEG_LO = 0;
  localparam int SEG_HI = 1;

  // Direction encoding of a port.
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;

  // Reset values.
  localparam logic DIR_RST = DIR_INPUT;
  localparam logic [NUM_LINES-1:0] MASK_RST = 8'h00;
  localparam logic [SEL_W-1:0] LINE_SEL_RST = 3'h0;
  localparam logic SEG_SEL_RST = 1'b0;

  // Port configuration state, Gray coded along reset, input, output.
  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_IN = 2'b01,
    ST_OUT = 2'b11
  } port_state_t;

endpackage

// ===== trig_line_mux.sv
// Selects one backplane trigger line of one segment for an output port.
// Assumes line vectors are synchronous; the caller registers only the chosen level.
`timescale 1ns/1ps
module trig_line_mux
  import trig_route_pkg::*;
(
  input wire logic [NUM_LINES-1:0] seg_lo_lines, // Segment 2 line levels.
  input wire logic [NUM_LINES-1:0] seg_hi_lines, // Segment 3 line levels.
  input wire logic [SEL_W-1:0] line_sel, // Chosen line index.
  input wire logic seg_sel, // Chosen segment, 1 for segment 3.
  output logic out_level // Level of the single chosen line.
);

  // Exactly one line feeds the output.
  always_comb
  begin
    out_level = seg_sel ? seg_hi_lines[line_sel] : seg_lo_lines[line_sel];
  end

endmodule // trig_line_mux

// ===== front_trigger_port_router.sv
// Routes two front trigger ports to backplane trigger segments 2 and 3.
// Assumes all inputs synchronous to CORE_CLK; pins resolved outside.
`timescale 1ns/1ps
module front_trigger_port_router
  import trig_route_pkg::*;
(
  input wire logic CORE_CLK, // System clock, 100 MHz.
  input wire logic NRST, // Synchronous reset, active low.
  input wire logic [NUM_PORTS-1:0] CFG_WE, // Config write strobe per port.
  input wire logic [NUM_PORTS-1:0] CFG_DIR, // New direction, 1 is output.
  input wire logic [2*NUM_PORTS*NUM_LINES-1:0] CFG_MASK, // Input fan-out.
  input wire logic [NUM_PORTS*SEL_W-1:0] CFG_LINE, // Output source line.
  input wire logic [NUM_PORTS-1:0] CFG_SEG, // Output source segment.
  input wire logic [NUM_LINES-1:0] ROUTE_LO, // Bridge route into segment 2.
  input wire logic [NUM_LINES-1:0] ROUTE_HI, // Bridge route into segment 3.
  input wire logic [NUM_PORTS-1:0] PORT_IN, // Front port pin input level.
  output logic [NUM_PORTS-1:0] PORT_OUT, // Front port pin drive level.
  output logic [NUM_PORTS-1:0] PORT_OE_N, // Front port enable, low drives.
  input wire logic [NUM_LINES-1:0] SEG_LO_IN, // Segment 2 line levels.
  input wire logic [NUM_LINES-1:0] SEG_HI_IN, // Segment 3 line levels.
  output logic [NUM_LINES-1:0] SEG_LO_OUT, // Segment 2 drive levels.
  output logic [NUM_LINES-1:0] SEG_LO_OE_N, // Segment 2 enable, low drives.
  output logic [NUM_LINES-1:0] SEG_HI_OUT, // Segment 3 drive levels.
  output logic [NUM_LINES-1:0] SEG_HI_OE_N // Segment 3 enable, low drives.
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state per port.

  port_state_t st_q [NUM_PORTS];
  port_state_t st_d [NUM_PORTS];
  logic [NUM_LINES-1:0] mlo_q [NUM_PORTS];
  logic [NUM_LINES-1:0] mlo_d [NUM_PORTS];
  logic [NUM_LINES-1:0] mhi_q [NUM_PORTS];
  logic [NUM_LINES-1:0] mhi_d [NUM_PORTS];
  logic [SEL_W-1:0] lsel_q [NUM_PORTS];
  logic [SEL_W-1:0] lsel_d [NUM_PORTS];
  logic ssel_q [NUM_PORTS];
  logic ssel_d [NUM_PORTS];
  logic [NUM_PORTS-1:0] mux_lvl;

  // True when a port state means it drives the backplane.
  function automatic logic is_input(input port_state_t s);
    is_input = (s == ST_IN);
  endfunction

  // True when a port state means it drives its front pin instead.
  function automatic logic is_output(input port_state_t s);
    is_output = (s == ST_OUT);
  endfunction

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      // Next configuration; any write applies with no commit step.
      always_comb
      begin
        st_d[p] = st_q[p];
        mlo_d[p] = mlo_q[p];
        mhi_d[p] = mhi_q[p];
        lsel_d[p] = lsel_q[p];
        ssel_d[p] = ssel_q[p];
        // Decode the present state; a write below may still override it.
        case (st_q[p])
          ST_RESET:
          begin
            // Reset lasts one cycle, so a write right after it still lands.
            st_d[p] = ST_IN;
          end
          ST_IN:
          begin
            st_d[p] = ST_IN;
          end
          ST_OUT:
          begin
            st_d[p] = ST_OUT;
          end
          default:
          begin
            // An unused code falls back to an input that drives nothing.
            st_d[p] = ST_IN;
            mlo_d[p] = MASK_RST;
            mhi_d[p] = MASK_RST;
          end
        endcase
        if (CFG_WE[p])
        begin
          // Settings are taken as given, even when they clash.
          if (CFG_DIR[p] == DIR_OUTPUT)
          begin
            st_d[p] = ST_OUT;
            lsel_d[p] = CFG_LINE[p*SEL_W +: SEL_W];
            ssel_d[p] = CFG_SEG[p];
          end
          else if (is_output(st_q[p]))
          begin
            // Turning to input starts with no lines driven.
            st_d[p] = ST_IN;
            mlo_d[p] = MASK_RST;
            mhi_d[p] = MASK_RST;
          end
          else
          begin
            st_d[p] = ST_IN;
            mlo_d[p] = CFG_MASK[(2*p)*NUM_LINES +: NUM_LINES];
            mhi_d[p] = CFG_MASK[(2*p+1)*NUM_LINES +: NUM_LINES];
          end
        end
      end

      // Registers only; reset loads ST_RESET, then input, with nothing selected.
      always_ff @(posedge CORE_CLK)
      begin
        if (!NRST)
        begin
          st_q[p] <= ST_RESET;
          mlo_q[p] <= MASK_RST;
          mhi_q[p] <= MASK_RST;
          lsel_q[p] <= LINE_SEL_RST;
          ssel_q[p] <= SEG_SEL_RST;
        end
        else
        begin
          st_q[p] <= st_d[p];
          mlo_q[p] <= mlo_d[p];
          mhi_q[p] <= mhi_d[p];
          lsel_q[p] <= lsel_d[p];
          ssel_q[p] <= ssel_d[p];
        end
      end

      trig_line_mux u_mux
      (
        .seg_lo_lines(SEG_LO_IN),
        .seg_hi_lines(SEG_HI_IN),
        .line_sel(lsel_q[p]),
        .seg_sel(ssel_q[p]),
        .out_level(mux_lvl[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Drive computation.

  logic [NUM_LINES-1:0] lo_out_d;
  logic [NUM_LINES-1:0] lo_oen_d;
  logic [NUM_LINES-1:0] hi_out_d;
  logic [NUM_LINES-1:0] hi_oen_d;
  logic [NUM_PORTS-1:0] pout_d;
  logic [NUM_PORTS-1:0] poen_d;
  logic [NUM_LINES-1:0] lo_out_q;
  logic [NUM_LINES-1:0] lo_oen_q;
  logic [NUM_LINES-1:0] hi_out_q;
  logic [NUM_LINES-1:0] hi_oen_q;
  logic [NUM_PORTS-1:0] pout_q;
  logic [NUM_PORTS-1:0] poen_q;
  logic [NUM_LINES-1:0] lo_claim;
  logic [NUM_LINES-1:0] hi_claim;

  // Each line takes at most one port, lowest port first, and never a line
  // that a bridge route already feeds. A clash of two ports is resolved by
  // priority rather than flagged, since nothing reports errors here.
  always_comb
  begin
    lo_out_d = '0;
    hi_out_d = '0;
    lo_claim = '0;
    hi_claim = '0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (is_input(st_q[i]))
      begin
        for (int l = 0; l < NUM_LINES; l++)
        begin
          // Selection under a route is dropped silently.
          if (mlo_q[i][l] && !ROUTE_LO[l] && !lo_claim[l])
          begin
            lo_claim[l] = 1'b1;
            lo_out_d[l] = PORT_IN[i];
          end
          if (mhi_q[i][l] && !ROUTE_HI[l] && !hi_claim[l])
          begin
            hi_claim[l] = 1'b1;
            hi_out_d[l] = PORT_IN[i];
          end
        end
      end
    end
    lo_oen_d = ~lo_claim;
    hi_oen_d = ~hi_claim;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      poen_d[i] = is_output(st_q[i]) ? 1'b0 : 1'b1;
      pout_d[i] = is_output(st_q[i]) ? mux_lvl[i] : 1'b0;
    end
  end

  // Output flops; reset releases every pin so nothing is driven.
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      lo_out_q <= '0;
      hi_out_q <= '0;
      lo_oen_q <= '1;
      hi_oen_q <= '1;
      pout_q <= '0;
      poen_q <= '1;
    end
    else
    begin
      lo_out_q <= lo_out_d;
      hi_out_q <= hi_out_d;
      lo_oen_q <= lo_oen_d;
      hi_oen_q <= hi_oen_d;
      pout_q <= pout_d;
      poen_q <= poen_d;
    end
  end

  assign SEG_LO_OUT = lo_out_q;
  assign SEG_LO_OE_N = lo_oen_q;
  assign SEG_HI_OUT = hi_out_q;
  assign SEG_HI_OE_N = hi_oen_q;
  assign PORT_OUT = pout_q;
  assign PORT_OE_N = poen_q;

endmodule // front_trigger_port_router

// ===== trig_router_assertions.sv
// Pin-level assertions for the front trigger port router.
// Assumes it is bound to the router and sees one clock domain.
`timescale 1ns/1ps
module trig_router_assertions
(
  input wire logic CORE_CLK, // Clock.
  input wire logic NRST, // Reset, active low.
  input wire logic [1:0] CFG_WE, // Write strobes.
  input wire logic [1:0] CFG_DIR, // Directions.
  input wire logic [7:0] ROUTE_LO, // Routes into segment 2.
  input wire logic [7:0] ROUTE_HI, // Routes into segment 3.
  input wire logic [1:0] PORT_IN, // Pin levels.
  input wire logic [1:0] PORT_OE_N, // Pin enables.
  input wire logic [7:0] SEG_LO_OUT, // Segment 2 drive.
  input wire logic [7:0] SEG_LO_OE_N, // Segment 2 enables.
  input wire logic [7:0] SEG_HI_OE_N // Segment 3 enables.
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////
  // Outputs are registered, so a route seen one edge back must mask.
  chk_reset_quiet: assert property ($past(!NRST) |->
    &{PORT_OE_N, SEG_LO_OE_N, SEG_HI_OE_N}) else $error("drive after reset");
  chk_route_lo_drop: assert property (
    (~SEG_LO_OE_N & $past(ROUTE_LO)) == 8'h00) else $error("routed lo");
  chk_route_hi_drop: assert property (
    (~SEG_HI_OE_N & $past(ROUTE_HI)) == 8'h00) else $error("routed hi");
  chk_outs_no_seg: assert property (PORT_OE_N == 2'b00 |->
    &{SEG_LO_OE_N, SEG_HI_OE_N}) else $error("segment driven");
  chk_fanout_data: assert property (PORT_OE_N == 2'b01 |->
    ((SEG_LO_OUT ^ {8{$past(PORT_IN[0])}}) & ~SEG_LO_OE_N) == 8'h00)
    else $error("fan-out level");
  chk_out_apply: assert property (CFG_WE[0] && CFG_DIR[0]
    ##1 !CFG_WE[0] |=> !PORT_OE_N[0]) else $error("output late");
  chk_in_apply: assert property (CFG_WE[0] && !CFG_DIR[0]
    ##1 !CFG_WE[0] |=> PORT_OE_N[0]) else $error("input late");
  chk_in_none: assert property ($past(CFG_WE) == 2'b00
    && CFG_WE == 2'b01 && !CFG_DIR[0] && PORT_OE_N == 2'b00
    ##1 CFG_WE == 2'b00 |=> &{SEG_LO_OE_N, SEG_HI_OE_N})
    else $error("default not none");
  cover property (CFG_WE == 2'b11 && CFG_DIR == 2'b11);
  cover property (PORT_OE_N == 2'b01 && !(&SEG_LO_OE_N));
  cover property (|ROUTE_HI && !(&SEG_HI_OE_N));
endmodule // trig_router_assertions

bind front_trigger_port_router trig_router_assertions u_chk (.CORE_CLK,
  .NRST, .CFG_WE, .CFG_DIR, .ROUTE_LO, .ROUTE_HI, .PORT_IN, .PORT_OE_N,
  .SEG_LO_OUT, .SEG_LO_OE_N, .SEG_HI_OE_N);

// ===== trig_backplane_model.sv
// Plug-in modules sharing the backplane trigger lines of two segments.
// Assumes enables are active low and lines resolve with no delay.
`timescale 1ns/1ps
module trig_backplane_model
(
  input wire logic [7:0] lo_oe_n, // Router enables, segment 2.
  input wire logic [7:0] lo_out, // Router levels, segment 2.
  input wire logic [7:0] hi_oe_n, // Router enables, segment 3.
  input wire logic [7:0] hi_out, // Router levels, segment 3.
  input wire logic [7:0] mod_lo, // Module levels, segment 2.
  input wire logic [7:0] mod_hi, // Module levels, segment 3.
  output logic [7:0] lo_line, // Resolved segment 2 lines.
  output logic [7:0] hi_line // Resolved segment 3 lines.
);
  // Modules step off any line the router drives, so one driver stays.
  // Segment 1 is left out: it is fed only by bridge routes into segment 2,
  // never by a front port directly.
  assign lo_line = (lo_out & ~lo_oe_n) | (mod_lo & lo_oe_n);
  assign hi_line = (hi_out & ~hi_oe_n) | (mod_hi & hi_oe_n);
endmodule // trig_backplane_model

// ===== front_trigger_port_router_tb_top.sv
// Self-checking bench for the front trigger port router.
// Assumes the backplane model resolves lines and a queue scoreboard.
`timescale 1ns/1ps
`define CHECK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, a); end end
module front_trigger_port_router_tb_top;
  logic CORE_CLK, NRST;
  logic [1:0] CFG_WE, CFG_DIR, CFG_SEG, PORT_IN, PORT_OUT, PORT_OE_N, eoe;
  logic [31:0] CFG_MASK;
  logic [5:0] CFG_LINE;
  logic [7:0] ROUTE_LO, ROUTE_HI, SEG_LO_IN, SEG_HI_IN, SEG_LO_OUT;
  logic [7:0] SEG_LO_OE_N, SEG_HI_OUT, SEG_HI_OE_N, mod_lo, mod_hi;
  logic [7:0] m_lo, m_hi;
  logic [2:0] line;
  logic [35:0] exp_q[$];
  logic [35:0] got;
  logic [35:0] exp_v;
  int n_errors, n_tests, seed;
  front_trigger_port_router u_dut (.CORE_CLK, .NRST, .CFG_WE, .CFG_DIR,
    .CFG_MASK, .CFG_LINE, .CFG_SEG, .ROUTE_LO, .ROUTE_HI, .PORT_IN,
    .PORT_OUT, .PORT_OE_N, .SEG_LO_IN, .SEG_HI_IN, .SEG_LO_OUT,
    .SEG_LO_OE_N, .SEG_HI_OUT, .SEG_HI_OE_N);
  trig_backplane_model u_bp (.lo_oe_n(SEG_LO_OE_N), .lo_out(SEG_LO_OUT),
    .hi_oe_n(SEG_HI_OE_N), .hi_out(SEG_HI_OUT), .mod_lo, .mod_hi,
    .lo_line(SEG_LO_IN), .hi_line(SEG_HI_IN));
  ////////////////////////////////////////////////////////////
  // Free-running clock.
  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  // One cycle of random levels; the note predicts the next edge.
  task automatic cyc(input logic [7:0] lo, input logic [7:0] hi,
    input logic chk);
    @(negedge CORE_CLK);
    {PORT_IN, mod_lo, mod_hi} = 18'($random(seed));
    if (chk)
      exp_q.push_back({eoe, mod_hi[line] & ~eoe[1],
        mod_lo[CFG_LINE[2:0]] & ~eoe[0],
        ~(lo & ~ROUTE_LO), ~(hi & ~ROUTE_HI),
        {8{PORT_IN[0]}} & lo & ~ROUTE_LO, {8{PORT_IN[0]}} & hi & ~ROUTE_HI});
  endtask
  // Oldest note is compared once the edge's updates have landed.
  always @(posedge CORE_CLK)
  begin
    #1;
    got = {PORT_OE_N, PORT_OUT, SEG_LO_OE_N, SEG_HI_OE_N,
      SEG_LO_OUT & ~SEG_LO_OE_N, SEG_HI_OUT & ~SEG_HI_OE_N};
    if (exp_q.size() > 0)
    begin
      // Pop once; the macro reads its expected argument more than once.
      exp_v = exp_q.pop_front();
      `CHECK("pins", exp_v, got)
    end
  end
  task automatic report_and_stop;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset, then rounds of output, cleared input and loaded fan-out.
  initial
  begin
    seed = 44;
    {NRST, CFG_WE, CFG_DIR, CFG_SEG, CFG_LINE, line} = '0;
    {CFG_MASK, ROUTE_LO, ROUTE_HI, PORT_IN, mod_lo, mod_hi} = '0;
    eoe = 2'b11;
    repeat (12) @(negedge CORE_CLK);
    NRST = 1'b1;
    repeat (3) cyc(8'h00, 8'h00, 1'b1);
    for (int r = 0; r < 12; r++)
    begin
      @(negedge CORE_CLK);
      {ROUTE_LO, ROUTE_HI, m_lo, m_hi} = $random(seed);
      line = 3'($random(seed));
      // Odd rounds keep bridge routes off the port's lines.
      if (r % 2 == 1)
        {ROUTE_LO, ROUTE_HI} = 16'h0000;
      m_hi[line] = 1'b0;
      CFG_MASK = {16'($random(seed)), m_hi, m_lo};
      CFG_LINE = {line, 3'($random(seed))};
      CFG_SEG = 2'b10;
      CFG_DIR = 2'b11;
      CFG_WE = 2'b11;
      eoe = 2'b00;
      // Modules and pins sit quiet while the ports are rewritten.
      {PORT_IN, mod_lo, mod_hi} = 18'h0;
      cyc(8'h00, 8'h00, 1'b0);
      CFG_WE = 2'b00;
      // Both ports are outputs: port 0 follows its segment 2 line.
      cyc(8'h00, 8'h00, 1'b1);
      CFG_DIR = 2'b10;
      CFG_WE = 2'b01;
      eoe = 2'b01;
      cyc(8'h00, 8'h00, 1'b1);
      CFG_WE = 2'b00;
      cyc(8'h00, 8'h00, 1'b1);
      CFG_WE = 2'b01;
      repeat (10)
      begin
        cyc(m_lo, m_hi, 1'b1);
        CFG_WE = 2'b00;
      end
    end
    // Mid-run reset while port 0 fans out; it must clear every mask.
    @(negedge CORE_CLK);
    NRST = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    NRST = 1'b1;
    eoe = 2'b11;
    repeat (3) cyc(8'h00, 8'h00, 1'b1);
    repeat (3) @(negedge CORE_CLK);
    report_and_stop();
  end
endmodule // front_trigger_port_router_tb_top
